// ==== core/passive_serial_config_chain.sv ====
/*
  passive serial configuration receiver with chain handling, jtag
  precedence and a jtag-to-flash bridge.
  assumes a host clocks config_bit_clock and the stream; shared
  status and completion lines are open drain with board pull-ups.
*/
`timescale 1ns/10ps
`default_nettype none

`include "psc_consts.svh"

// What this block does
// - take config as one-bit stream on host clock
// - chained devices enter user mode together
// - error pulls status low, resets whole chain
// - done drives chain output low for next
// - chain output off unless option enables it
// - tied chain enables start and end together
// - jtag configuration overrides every other scheme
// - no decompression or security under jtag
// - global clear and enable spare jtag operations
// - loaded logic bridges jtag to serial flash
// - user clock lets initialisation finish alone
module passive_serial_config_chain #(
  parameter logic [15:0] STREAM_BYTES = `PSC_STREAM_BYTES
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       config_bit_clock,
  input  wire logic       serial_config_data_in,
  input  wire logic [1:0] scheme_select,
  input  wire logic       config_restart_n,
  input  wire logic       config_status_n_in,
  output logic            config_status_n_out,
  output logic            config_status_n_oe,
  input  wire logic       config_complete_in,
  output logic            config_complete_out,
  output logic            config_complete_oe,
  input  wire logic       chain_enable_in_n,
  output logic            chain_enable_out_n,
  output logic            chain_enable_out_n_oe,
  input  wire logic       jtag_config_active,
  input  wire logic       jtag_bridge_enable,
  input  wire logic       jtag_tdi,
  output logic            jtag_tdo,
  output logic            flash_serial_config_data_in_out,
  output logic            flash_serial_config_data_in_oe,
  input  wire logic       flash_readback_line,
  input  wire logic       global_clear_n,
  input  wire logic       global_output_enable,
  output logic            user_mode,
  output logic            user_reset_n,
  output logic            user_io_enable,
  output logic            decompress_enable,
  output logic            security_enable,
  output logic            config_error
);

  // ***********************************************************
  // declarations
  // ***********************************************************
  psc_pkg::core_t          c_q;      // core-domain state
  psc_pkg::core_t          c_d;      // its next value
  psc_pkg::link_t          l_q;      // link-domain state
  psc_pkg::link_t          l_d;      // its next value
  logic [`PSC_PIN_W-1:0]   pin_raw;  // pins before crossing
  logic [`PSC_PIN_W-1:0]   pin_s;    // pins after two flops
  logic                    rx_en_l;  // receive enable, link side
  logic                    byte_evt; // new byte seen in core
  logic [7:0]              sum_nx;   // running check incl. byte

  // pin order must follow the position constants
  assign pin_raw = {l_q.tog, scheme_select, flash_readback_line,
                    jtag_tdi, global_output_enable, global_clear_n,
                    jtag_bridge_enable, jtag_config_active,
                    chain_enable_in_n, config_complete_in,
                    config_status_n_in, config_restart_n};

  // ***********************************************************
  // crossings
  // ***********************************************************
  // pins and the byte toggle into the core clock
  psc_sync #(.WIDTH(`PSC_PIN_W)) u_sync_core (
    .clk      (core_clk),
    .reset    (reset),
    .async_in (pin_raw),
    .sync_out (pin_s)
  );

  // receive enable into the link clock
  psc_sync #(.WIDTH(1)) u_sync_link (
    .clk      (config_bit_clock),
    .reset    (reset),
    .async_in (c_q.rx_en),
    .sync_out (rx_en_l)
  );

  // ***********************************************************
  // link domain: bit shifter
  // ***********************************************************
  // the held byte stays stable for eight bit clocks after the
  // toggle flips, which dwarfs the core-side sync delay
  always_comb
  begin
    l_d = l_q;
    if (rx_en_l)
    begin
      // first bit on the line lands in bit 0
      l_d.shift  = {serial_config_data_in, l_q.shift[7:1]};
      l_d.bitcnt = l_q.bitcnt + 3'h1;
      if (l_q.bitcnt == `PSC_LAST_BIT)
      begin
        l_d.byte_q = {serial_config_data_in, l_q.shift[7:1]};
        l_d.tog    = ~l_q.tog;
      end
    end
    else
    begin
      // realign to a byte boundary between frames
      l_d.bitcnt = 3'h0;
    end
  end

  // rising edge of the host clock samples the data pin
  always_ff @(posedge config_bit_clock or posedge reset)
  begin
    if (reset)
    begin
      l_q <= '0;
    end
    else
    begin
      l_q <= l_d;
    end
  end

  // ***********************************************************
  // core domain: configuration sequence
  // ***********************************************************
  assign byte_evt = pin_s[`PSC_PIN_TOGGLE] != c_q.tog_seen;
  assign sum_nx   = c_q.sum ^ l_q.byte_q;

  always_comb
  begin
    c_d          = c_q;
    c_d.tog_seen = pin_s[`PSC_PIN_TOGGLE];
    // open-drain lines only ever pull low
    c_d.status_oe = 1'b0;
    case (c_q.st)
      // held in reset until the scheme pins select passive serial
      psc_pkg::ST_IDLE:
      begin
        c_d.status_oe   = 1'b1;
        c_d.complete_oe = 1'b1;
        c_d.user_mode   = 1'b0;
        c_d.rx_en       = 1'b0;
        c_d.err         = 1'b0;
        c_d.ceo_n       = 1'b1;
        if (pin_s[`PSC_PIN_SCHEME +: 2] == `PSC_PASSIVE_SERIAL_SCHEME)
        begin
          c_d.status_oe = 1'b0;
          c_d.st        = psc_pkg::ST_WAIT;
        end
      end
      // a low chain enable starts reception; tied-low chains
      // therefore start on the same stream bit
      psc_pkg::ST_WAIT:
      begin
        // wait for the shared status line to read released, so our own
        // release still crossing the synchroniser is not taken as an error
        if (!pin_s[`PSC_PIN_CE] && pin_s[`PSC_PIN_STATUS])
        begin
          c_d.st    = psc_pkg::ST_RECV;
          c_d.rx_en = 1'b1;
          c_d.cnt   = 16'h0;
          c_d.sum   = 8'h0;
        end
      end
      // first byte is the option byte, last is the check byte
      psc_pkg::ST_RECV:
      begin
        if (byte_evt)
        begin
          c_d.sum = sum_nx;
          c_d.cnt = c_q.cnt + 16'h1;
          if (c_q.cnt == 16'h0)
          begin
            c_d.opt = l_q.byte_q;
          end
          if (c_q.cnt == STREAM_BYTES - 16'h1)
          begin
            c_d.cnt = 16'h0;
            if (sum_nx != 8'h0)
            begin
              c_d.st = psc_pkg::ST_ERROR;
            end
            else
            begin
              // whole stream clean: let go of completion
              c_d.st          = psc_pkg::ST_INIT;
              c_d.complete_oe = 1'b0;
              // next device enabled only if the option asks
              c_d.ceo_n  = 1'b0;
              c_d.ceo_oe = c_q.opt[`PSC_OPT_CHAIN];
            end
          end
        end
      end
      // initialisation: on the user clock when enabled, else on
      // extra host clocking (counted in bytes)
      psc_pkg::ST_INIT:
      begin
        if (c_q.opt[`PSC_OPT_USERCLK] || byte_evt)
        begin
          if (c_q.cnt != `PSC_INIT_COUNT)
          begin
            c_d.cnt = c_q.cnt + 16'h1;
          end
        end
        // shared completion high means every device is done
        if (c_q.cnt == `PSC_INIT_COUNT && pin_s[`PSC_PIN_COMPLETE])
        begin
          c_d.st        = psc_pkg::ST_USER;
          c_d.user_mode = 1'b1;
          c_d.rx_en     = 1'b0;
        end
      end
      psc_pkg::ST_USER:
      begin
        c_d.user_mode = 1'b1;
      end
      // hold status low until restart; whole chain must reload
      psc_pkg::ST_ERROR:
      begin
        c_d.status_oe = 1'b1;
        c_d.err       = 1'b1;
        c_d.rx_en     = 1'b0;
      end
      default:
      begin
        c_d.st = psc_pkg::ST_IDLE;
      end
    endcase

    // another device pulled status low: halt and restart
    if (!c_q.status_oe && !pin_s[`PSC_PIN_STATUS] &&
        c_q.st != psc_pkg::ST_IDLE && c_q.st != psc_pkg::ST_WAIT &&
        c_q.st != psc_pkg::ST_USER)
    begin
      c_d.st    = psc_pkg::ST_IDLE;
      c_d.rx_en = 1'b0;
    end
    // restart low (cable holds it while writing flash), high
    // chain enable already blocks reception in wait
    if (!pin_s[`PSC_PIN_RESTART])
    begin
      c_d.st        = psc_pkg::ST_IDLE;
      c_d.status_oe = 1'b1;
      c_d.rx_en     = 1'b0;
      c_d.ceo_oe    = 1'b0;
    end
    // jtag configuration beats the serial scheme
    if (pin_s[`PSC_PIN_JTAG])
    begin
      c_d.st     = psc_pkg::ST_IDLE;
      c_d.rx_en  = 1'b0;
      c_d.ceo_oe = 1'b0;
    end
    // any way back to idle holds completion low and frees the chain
    if (c_d.st == psc_pkg::ST_IDLE)
    begin
      c_d.complete_oe = 1'b1;
      c_d.ceo_oe      = 1'b0;
    end

    // user outputs; global pins ignored while jtag works
    c_d.user_rst_n = c_d.user_mode &
                     (pin_s[`PSC_PIN_CLR] | pin_s[`PSC_PIN_JTAG]);
    c_d.io_en      = c_d.user_mode &
                     (pin_s[`PSC_PIN_GOE] | pin_s[`PSC_PIN_JTAG]);
    c_d.dec_en = c_d.user_mode & c_q.opt[`PSC_OPT_DECOMP] &
                 ~pin_s[`PSC_PIN_JTAG];
    c_d.sec_en = c_d.user_mode & c_q.opt[`PSC_OPT_SECURE] &
                 ~pin_s[`PSC_PIN_JTAG];

    // flash bridge: tdi out on data zero, line one back to tdo
    c_d.flash_oe = c_q.user_mode & pin_s[`PSC_PIN_BRIDGE];
    c_d.flash_d0 = c_d.flash_oe & pin_s[`PSC_PIN_TDI];
    c_d.tdo      = c_d.flash_oe & pin_s[`PSC_PIN_READBACK];
  end

  // reset holds status and completion low, chain output off
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      c_q             <= '0;
      c_q.st          <= psc_pkg::ST_IDLE;
      c_q.status_oe   <= 1'b1;
      c_q.complete_oe <= 1'b1;
      c_q.ceo_n       <= 1'b1;
    end
    else
    begin
      c_q <= c_d;
    end
  end

  // ***********************************************************
  // outputs, all straight from flops
  // ***********************************************************
  assign config_status_n_out   = c_q.err & 1'b0;
  assign config_status_n_oe    = c_q.status_oe;
  assign config_complete_out   = c_q.err & 1'b0;
  assign config_complete_oe    = c_q.complete_oe;
  assign chain_enable_out_n    = c_q.ceo_n;
  assign chain_enable_out_n_oe = c_q.ceo_oe;
  assign jtag_tdo              = c_q.tdo;
  assign flash_serial_config_data_in_out       = c_q.flash_d0;
  assign flash_serial_config_data_in_oe        = c_q.flash_oe;
  assign user_mode             = c_q.user_mode;
  assign user_reset_n          = c_q.user_rst_n;
  assign user_io_enable        = c_q.io_en;
  assign decompress_enable     = c_q.dec_en;
  assign security_enable       = c_q.sec_en;
  assign config_error          = c_q.err;

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_recv_start;
    $rose(c_q.rx_en) |-> $past(!pin_s[`PSC_PIN_CE]);
  endproperty
  a_recv_start: assert property (p_recv_start)
    else $error("reception began without chain enable");

  property p_err_status;
    c_q.st == psc_pkg::ST_ERROR |-> ##1 c_q.status_oe;
  endproperty
  a_err_status: assert property (p_err_status)
    else $error("error state did not pull status low");

  property p_complete_release;
    !c_q.complete_oe |-> c_q.st inside {psc_pkg::ST_INIT, psc_pkg::ST_USER};
  endproperty
  a_complete_release: assert property (p_complete_release)
    else $error("completion released before clean stream");

  property p_user_together;
    $rose(c_q.user_mode) |-> $past(pin_s[`PSC_PIN_COMPLETE]);
  endproperty
  a_user_together: assert property (p_user_together)
    else $error("user mode entered with completion low");

  property p_chain_gate;
    c_q.ceo_oe |-> c_q.opt[`PSC_OPT_CHAIN] && !c_q.ceo_n;
  endproperty
  a_chain_gate: assert property (p_chain_gate)
    else $error("chain output driven without option");

  property p_chain_done;
    $fell(c_q.complete_oe) |-> !c_q.ceo_n;
  endproperty
  a_chain_done: assert property (p_chain_done)
    else $error("chain output not low on completion");

  property p_jtag_wins;
    pin_s[`PSC_PIN_JTAG] |=> c_q.st == psc_pkg::ST_IDLE && !c_q.rx_en;
  endproperty
  a_jtag_wins: assert property (p_jtag_wins)
    else $error("jtag did not take over configuration");

  property p_no_dec_jtag;
    pin_s[`PSC_PIN_JTAG] |=> !c_q.dec_en && !c_q.sec_en;
  endproperty
  a_no_dec_jtag: assert property (p_no_dec_jtag)
    else $error("decompression or security under jtag");

  property p_restart_hold;
    !pin_s[`PSC_PIN_RESTART] |=>
      c_q.status_oe && c_q.st == psc_pkg::ST_IDLE && !c_q.rx_en;
  endproperty
  a_restart_hold: assert property (p_restart_hold)
    else $error("restart low did not hold status low");

  property p_global_spare;
    pin_s[`PSC_PIN_JTAG] && c_q.st == psc_pkg::ST_USER |=>
      c_q.user_rst_n == c_q.user_mode;
  endproperty
  a_global_spare: assert property (p_global_spare)
    else $error("global clear acted during jtag");

  c_stream_ok: cover property (c_q.st == psc_pkg::ST_RECV ##[1:1000]
                               c_q.st == psc_pkg::ST_INIT);
  c_stream_err: cover property ($rose(c_q.err));
  c_bridge: cover property ($rose(c_q.flash_oe));

endmodule // passive_serial_config_chain

`default_nettype wire

// ==== shared/psc_consts.svh ====
/*
  constants for the passive serial configuration receiver: pin
  positions in the synchroniser vector, option bits, counts.
  assumes it is included by its bare name, once per unit.
*/
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH

// ***********************************************************
// scheme and option byte
// ***********************************************************
`define PSC_PASSIVE_SERIAL_SCHEME 2'h2
`define PSC_OPT_CHAIN    0
`define PSC_OPT_DECOMP   1
`define PSC_OPT_SECURE   2
`define PSC_OPT_USERCLK  3

// ***********************************************************
// counts
// ***********************************************************
`define PSC_STREAM_BYTES 16'h0100
`define PSC_INIT_COUNT   16'h0040
`define PSC_LAST_BIT     3'h7

// ***********************************************************
// positions in the synchronised pin vector
// ***********************************************************
`define PSC_PIN_RESTART  0
`define PSC_PIN_STATUS   1
`define PSC_PIN_COMPLETE 2
`define PSC_PIN_CE       3
`define PSC_PIN_JTAG     4
`define PSC_PIN_BRIDGE   5
`define PSC_PIN_CLR      6
`define PSC_PIN_GOE      7
`define PSC_PIN_TDI      8
`define PSC_PIN_READBACK 9
`define PSC_PIN_SCHEME   10
`define PSC_PIN_TOGGLE   12
`define PSC_PIN_W        13

`endif

// ==== shared/psc_pkg.sv ====
/*
  types of the passive serial configuration receiver.
  assumes psc_consts.svh is on the include path.
*/
`include "psc_consts.svh"

package psc_pkg;

  // configuration sequence of the core domain
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_RECV, ST_INIT, ST_USER, ST_ERROR
  } state_t;

  // whole core-domain state
  typedef struct packed {
    state_t      st;
    logic [7:0]  opt;
    logic [15:0] cnt;
    logic [7:0]  sum;
    logic        tog_seen;
    logic        rx_en;
    logic        status_oe;
    logic        complete_oe;
    logic        ceo_n;
    logic        ceo_oe;
    logic        user_mode;
    logic        user_rst_n;
    logic        io_en;
    logic        dec_en;
    logic        sec_en;
    logic        flash_d0;
    logic        flash_oe;
    logic        tdo;
    logic        err;
  } core_t;

  // whole link-domain state
  typedef struct packed {
    logic [7:0] shift;
    logic [2:0] bitcnt;
    logic [7:0] byte_q;
    logic       tog;
  } link_t;

endpackage

// ==== core/psc_sync.sv ====
/*
  two flip-flop synchroniser, one chain per bit.
  assumes asynchronous active-high reset of the receiving domain.
*/
`timescale 1ns/10ps
`default_nettype none

module psc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ***********************************************************
  // one chain per bit
  // ***********************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_q;  // only read by the second stage
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          meta_q      <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta_q      <= async_in[i];
          sync_out[i] <= meta_q;
        end
      end
    end
  endgenerate

endmodule // psc_sync

`default_nettype wire

// ==== dv/psc_host.sv ====
/*
  host side model of the passive serial stream: makes the configuration
  bit clock and the serial data line.
  assumes the bench calls its tasks one at a time; the clock rests low
  outside frames and the data line never keeps its last bit when idle.
*/
`timescale 1ns/10ps
`default_nettype none

module psc_host (
  output var logic config_bit_clock,
  output var logic serial_config_data_in
);
  // ***********************************************************
  // bit clock and data
  // ***********************************************************
  localparam realtime HALF = 6.0;  // half of the 12 ns bit clock

  // resting levels at time zero
  initial
  begin
    config_bit_clock      = 1'b0;
    serial_config_data_in = 1'b0;
  end

  // one bit: data settles while the clock is low, device takes it on the rise
  task automatic put_bit(input logic b);
    serial_config_data_in = b;
    #HALF config_bit_clock = 1'b1;
    #HALF config_bit_clock = 1'b0;
  endtask

  // filler clocks whose bits the device must drop; also lets reset reach the link side
  task automatic idle_clocks(input int n);
    repeat (n) put_bit(~serial_config_data_in);
  endtask

  // whole frame: two filler clocks so the receive enable crosses, then bytes
  task automatic send_frame(input logic [7:0] bytes [$]);
    #3.3;  // keep the frame out of phase with the core clock
    idle_clocks(2);
    foreach (bytes[i])
      for (int k = 0; k < 8; k++)
        put_bit(bytes[i][k]);
    // released line: never leave the last bit standing
    serial_config_data_in = ~serial_config_data_in;
  endtask
endmodule // psc_host

`default_nettype wire

// ==== dv/tb.sv ====
/*
  self-checking bench of the passive serial configuration receiver.
  assumes a four-byte stream (option, two data, check) and board pull-ups
  on the shared status and completion lines, modelled here as wired-and.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  // ***********************************************************
  // signals
  // ***********************************************************
  logic       core_clk;               // 100 MHz core clock
  logic       reset;                  // async, active high
  wire        config_bit_clock;       // made by the host model
  wire        serial_config_data_in;  // made by the host model
  logic [1:0] scheme_select;          // strap pins
  logic       config_restart_n;       // restart pin
  wire        config_status_n_in;     // wired status line
  logic       config_status_n_oe;     // device pulls status low
  wire        config_complete_in;     // wired completion line
  logic       config_complete_oe;     // device holds completion low
  logic       other_done;             // second device lets completion rise
  logic       chain_enable_in_n;      // chain enable in
  logic       chain_enable_out_n;     // chain enable out
  logic       chain_enable_out_n_oe;  // chain enable out drive
  logic       jtag_config_active;     // jtag configuration pin
  logic       jtag_bridge_enable;     // bridge request
  logic       jtag_tdi;               // jtag data in
  logic       jtag_tdo;               // jtag readback
  logic       flash_serial_config_data_in_out;        // flash data line zero
  logic       flash_serial_config_data_in_oe;         // flash data line drive
  logic       flash_readback_line;    // flash data line one
  logic       global_clear_n;         // chip-wide clear
  logic       global_output_enable;   // chip-wide output enable
  logic       user_mode;              // device in user mode
  logic       user_reset_n;           // user logic reset
  logic       user_io_enable;         // user pins enabled
  logic       decompress_enable;      // decompression on
  logic       security_enable;        // security on
  logic       config_error;           // error flag
  int         error_cnt;              // mismatches seen
  int         samples_checked;        // comparisons made

  // open-drain lines: released means pulled high
  assign config_status_n_in = ~config_status_n_oe;
  assign config_complete_in = ~config_complete_oe & other_done;

  // ***********************************************************
  // instances
  // ***********************************************************
  psc_host i_psc_host (
    .config_bit_clock      (config_bit_clock),
    .serial_config_data_in (serial_config_data_in)
  );

  passive_serial_config_chain #(
    .STREAM_BYTES (16'h0004)
  ) i_passive_serial_config_chain (
    .core_clk              (core_clk),
    .reset                 (reset),
    .config_bit_clock      (config_bit_clock),
    .serial_config_data_in (serial_config_data_in),
    .scheme_select         (scheme_select),
    .config_restart_n      (config_restart_n),
    .config_status_n_in    (config_status_n_in),
    .config_status_n_out   (),
    .config_status_n_oe    (config_status_n_oe),
    .config_complete_in    (config_complete_in),
    .config_complete_out   (),
    .config_complete_oe    (config_complete_oe),
    .chain_enable_in_n     (chain_enable_in_n),
    .chain_enable_out_n    (chain_enable_out_n),
    .chain_enable_out_n_oe (chain_enable_out_n_oe),
    .jtag_config_active    (jtag_config_active),
    .jtag_bridge_enable    (jtag_bridge_enable),
    .jtag_tdi              (jtag_tdi),
    .jtag_tdo              (jtag_tdo),
    .flash_serial_config_data_in_out       (flash_serial_config_data_in_out),
    .flash_serial_config_data_in_oe        (flash_serial_config_data_in_oe),
    .flash_readback_line   (flash_readback_line),
    .global_clear_n        (global_clear_n),
    .global_output_enable  (global_output_enable),
    .user_mode             (user_mode),
    .user_reset_n          (user_reset_n),
    .user_io_enable        (user_io_enable),
    .decompress_enable     (decompress_enable),
    .security_enable       (security_enable),
    .config_error          (config_error)
  );

  // ***********************************************************
  // helpers
  // ***********************************************************
  // free-running core clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // move just past a core edge so every input change lands off it
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // one comparison of a single-bit result
  task automatic chk(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  // verdict and end of run
  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // full reset with pins at their idle levels; link side sees clocks too
  task automatic do_reset();
    reset                = 1'b1;
    scheme_select        = 2'h2;
    config_restart_n     = 1'b1;
    chain_enable_in_n    = 1'b0;
    other_done           = 1'b1;
    jtag_config_active   = 1'b0;
    jtag_bridge_enable   = 1'b0;
    jtag_tdi             = 1'b0;
    flash_readback_line  = 1'b1;
    global_clear_n       = 1'b1;
    global_output_enable = 1'b1;
    fork
      i_psc_host.idle_clocks(2);
      step(6);
    join
    reset = 1'b0;
    step(10);  // status release and receive enable need a few edges
  endtask

  // stream of option, two data bytes and check byte; bad spoils the check
  task automatic run_cfg(input logic [7:0] opt, input logic bad);
    logic [7:0] q [$];
    q = {opt, 8'ha5, 8'h3c, opt ^ 8'h99 ^ {7'h00, bad}};
    i_psc_host.send_frame(q);
    step(1);
  endtask

  // bounded wait for the end of the stream to be taken
  task automatic wait_cpl();
    for (int i = 0; i < 20 && config_complete_oe !== 1'b0; i++) step(1);
  endtask

  // bounded wait for user mode (init counts 64 core cycles)
  task automatic wait_user();
    for (int i = 0; i < 120 && user_mode !== 1'b1; i++) step(1);
  endtask

  // ***********************************************************
  // scenarios
  // ***********************************************************
  // chained device: completion only after a clean stream, then hand-off
  task automatic t_chain();
    do_reset();
    other_done = 1'b0;  // a later device is still configuring
    run_cfg(8'h09, 1'b0);
    chk("complete held", 1'b1, config_complete_oe);
    wait_cpl();
    chk("complete released", 1'b0, config_complete_oe);
    chk("chain out", 1'b0, chain_enable_out_n);
    chk("chain out drive", 1'b1, chain_enable_out_n_oe);
    wait_user();
    chk("user mode early", 1'b0, user_mode);
    other_done = 1'b1;
    wait_user();
    chk("user mode", 1'b1, user_mode);
    step(2);
    chk("user reset", 1'b1, user_reset_n);
    chk("user io", 1'b1, user_io_enable);
  endtask

  // option leaves the chain output off
  task automatic t_nochain();
    do_reset();
    run_cfg(8'h08, 1'b0);
    wait_cpl();
    chk("chain drive off", 1'b0, chain_enable_out_n_oe);
  endtask

  // spoiled check byte pulls status low and holds completion
  task automatic t_error();
    do_reset();
    run_cfg(8'h08, 1'b1);
    for (int i = 0; i < 20 && config_error !== 1'b1; i++) step(1);
    chk("error flag", 1'b1, config_error);
    chk("status pulled", 1'b1, config_status_n_oe);
    chk("complete held", 1'b1, config_complete_oe);
    config_restart_n = 1'b0;
    step(6);
    chk("restart holds", 1'b1, config_status_n_oe);
    config_restart_n = 1'b1;
    step(6);
    chk("error cleared", 1'b0, config_error);
  endtask

  // jtag takes over from user mode and turns off decompression and security
  task automatic t_jtag();
    do_reset();
    run_cfg(8'h0e, 1'b0);
    wait_user();
    chk("decompress on", 1'b1, decompress_enable);
    chk("security on", 1'b1, security_enable);
    jtag_config_active = 1'b1;
    step(6);
    chk("user mode left", 1'b0, user_mode);
    chk("decompress off", 1'b0, decompress_enable);
    chk("security off", 1'b0, security_enable);
  endtask

  // bridge relays tdi to flash line zero and line one back to tdo
  task automatic t_bridge();
    do_reset();
    run_cfg(8'h08, 1'b0);
    wait_user();
    jtag_bridge_enable  = 1'b1;
    jtag_tdi            = 1'b1;
    flash_readback_line = 1'b0;
    step(5);
    chk("flash drive", 1'b1, flash_serial_config_data_in_oe);
    chk("flash data one", 1'b1, flash_serial_config_data_in_out);
    chk("tdo zero", 1'b0, jtag_tdo);
    jtag_tdi            = 1'b0;
    flash_readback_line = 1'b1;
    step(5);
    chk("flash data zero", 1'b0, flash_serial_config_data_in_out);
    chk("tdo one", 1'b1, jtag_tdo);
  endtask

  // ***********************************************************
  // main sequence and watchdog
  // ***********************************************************
  initial
  begin
    error_cnt       = 0;
    samples_checked = 0;
    reset           = 1'b1;
    t_chain();
    t_nochain();
    t_error();
    t_jtag();
    t_bridge();
    finish_test();
  end

  // all scenarios take a few microseconds; this bound cuts a hang
  initial
  begin
    #100000;
    error_cnt++;
    finish_test();
  end
endmodule // tb

`default_nettype wire
